// >>> isabc_pkg.sv
/*
 Package for the expansion-bus partner: the bus master and card that sit
 opposite the system controller. Assumes every controller pin reaches the
 host through the testbench wire model, active-low where the bus says so.
*/
// Notes on behaviour
// - during master operation the memory write strobe is driven by the master.
// - glue combines qualifier with memory strobes into small-memory strobes.
// - early address 20 is output normally, master-driven during master operation.
// - system address 0 is output normally, master-driven during master operation.
// - a master may assert refresh with memory read to refresh all memory.
// - master asserts its ownership line; controller releases address and strobes.
// - card asserting its 16-bit I/O line makes the I/O cycle 16 bits wide.
// - card asserting its 16-bit memory line makes the memory cycle 16 bits.
// - card asserting zero-wait ends the cycle without default wait states.
// - card holding ready low keeps wait states until ready returns.
// - I/O strobes are controller outputs normally, master-driven in master operation.
package isabc_pkg;
  typedef enum logic [2:0] {
    ISABC_MEM_RD = 3'h0,
    ISABC_MEM_WR = 3'h1,
    ISABC_IO_RD = 3'h2,
    ISABC_IO_WR = 3'h3,
    ISABC_REFRESH = 3'h4
  } isabc_kind_t;

  typedef struct packed {
    isabc_kind_t kind;
    logic [23:0] addr;
  } isabc_req_t;

  // active-low command strobes
  typedef struct packed {
    logic memr_n;
    logic memw_n;
    logic ior_n;
    logic iow_n;
  } isabc_cmd_t;

  localparam int ISABC_ADDR_LA20 = 20;
  localparam int ISABC_ADDR_SA0 = 0;
  // master cycle timing counted in bus system clock rising edges
  localparam logic [3:0] ISABC_ACQ_TICKS = 4'h2;
  localparam logic [3:0] ISABC_ADDR_TICKS = 4'h1;
  localparam logic [3:0] ISABC_CMD_TICKS = 4'h3;
  localparam logic [3:0] ISABC_END_TICKS = 4'h1;
  localparam isabc_cmd_t ISABC_CMD_IDLE = 4'hf;
  // idle pin levels in synchroniser order: sysclk, bale, aen, qualifier, ack enable,
  // select, strobes, refresh; a reset to these avoids false edges and stray acks
  localparam logic [12:0] ISABC_PIN_IDLE = 13'h021f;

  // select code -> source bit, three bits per code, code 0 in the low bits
  localparam logic [23:0] ISABC_DRQ_MAP = 24'hfac688;
  localparam logic [23:0] ISABC_SET1_MAP = 24'hfac688;
  localparam logic [23:0] ISABC_SET0_MAP = 24'hfac688;
  localparam logic [23:0] ISABC_PMC_MAP = 24'hfac688;
  // select code -> acknowledge channel; channel 4 stands for bus reset
  localparam logic [23:0] ISABC_ACK_MAP = 24'hfac688;
  localparam logic [2:0] ISABC_ACK_BUS_RESET = 3'h4;

  function automatic logic [2:0] isabc_map(input logic [23:0] map, input logic [2:0] code);
    isabc_map = map[code*3 +: 3];
  endfunction
endpackage

// >>> isabc_host.sv
/*
 Expansion-bus partner: an external bus master that takes the bus and runs
 memory, I/O and refresh cycles, a card that answers the controller's cycles,
 the small-memory strobe glue and the external select-line multiplexer.
 Assumes all controller pins arrive asynchronously and the wire model resolves
 each driven pin from its output enable.
*/
`timescale 1ns/1ps
`default_nettype none
module isabc_host (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // user request port
  input wire logic req_valid_i,
  input wire isabc_pkg::isabc_req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  // card behaviour and error sources
  input wire logic card_io16_i,
  input wire logic card_mem16_i,
  input wire logic card_zero_wait_i,
  input wire logic card_not_ready_i,
  input wire logic chan_error_i,
  // multiplexer sources, ordered by the select tables
  input wire logic [7:0] drq_src_i,
  input wire logic [7:0] set1_src_i,
  input wire logic [7:0] set0_src_i,
  input wire logic [7:0] pmc_src_i,
  // controller outputs
  input wire logic sysclk_i,
  input wire logic bale_i,
  input wire logic aen_i,
  input wire logic low_megabyte_qualifier_n_i,
  input wire logic acknowledge_decode_enable_i,
  input wire logic mux_select_bit2_i,
  input wire logic mux_select_bit1_i,
  input wire logic mux_select_bit0_i,
  // two-way pins, input side
  input wire isabc_pkg::isabc_cmd_t cmd_i,
  input wire logic refresh_n_i,
  // two-way pins, driven side
  output isabc_pkg::isabc_cmd_t cmd_o,
  output logic cmd_oe_o,
  output logic la20_o,
  output logic la20_oe_o,
  output logic sa0_o,
  output logic sa0_oe_o,
  output logic refresh_n_o,
  output logic refresh_oe_o,
  // master and card lines
  output logic master_n_o,
  output logic io16_n_o,
  output logic mem16_n_o,
  output logic zero_wait_n_o,
  output logic iochrdy_o,
  output logic channel_check_input_n_o,
  // glue and multiplexer outputs
  output logic small_memr_n_o,
  output logic small_memw_n_o,
  output logic multiplexed_request_input_o,
  output logic interrupt_set_input_one_o,
  output logic interrupt_set_input_zero_o,
  output logic power_management_mux_input_o,
  output logic [7:0] dma_ack_n_o,
  output logic bus_reset_o
);
  import isabc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACQ = 5'h02,
    ST_ADDR = 5'h04,
    ST_CMD = 5'h08,
    ST_END = 5'h10
  } isabc_state_t;

  // two-stage synchronisers for every controller pin
  localparam int SW = 13;
  logic [SW-1:0] sync1, sync2, sync_in;
  assign sync_in = {sysclk_i, bale_i, aen_i, low_megabyte_qualifier_n_i,
                    acknowledge_decode_enable_i, mux_select_bit2_i, mux_select_bit1_i,
                    mux_select_bit0_i, cmd_i, refresh_n_i};
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= ISABC_PIN_IDLE;
      sync2 <= ISABC_PIN_IDLE;
    end else begin
      sync1 <= sync_in;
      sync2 <= sync1;
    end
  end
  logic sclk_s, low_megabyte_qualifier_n_s, acken_s, refresh_s_n;
  logic [2:0] sel_s;
  isabc_cmd_t cmd_s;
  assign sclk_s = sync2[12];
  assign low_megabyte_qualifier_n_s = sync2[9];
  assign acken_s = sync2[8];
  assign sel_s = sync2[7:5];
  assign cmd_s = sync2[4:1];
  assign refresh_s_n = sync2[0];

  // sysclk rising edge gives the one-cycle tick for the master sequence
  logic sclk_d, tick;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) sclk_d <= 1'b0;
    else sclk_d <= sclk_s;
  end
  assign tick = sclk_s & ~sclk_d;

  // master sequencer
  isabc_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  isabc_req_t cur, next_cur;
  isabc_cmd_t next_cmd;
  logic next_master_n, next_oe, next_refresh_n, next_done, next_ready;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cur = cur;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_cur = req_i;
          next_cnt = ISABC_ACQ_TICKS;
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // pins stay released until the controller has had time to let go
        if (tick) begin
          if (cnt == 4'h1) begin
            next_cnt = ISABC_ADDR_TICKS;
            next_state = ST_ADDR;
          end else next_cnt = cnt - 4'h1;
        end
      end
      ST_ADDR: begin
        if (tick) begin
          if (cnt == 4'h1) begin
            next_cnt = ISABC_CMD_TICKS;
            next_state = ST_CMD;
          end else next_cnt = cnt - 4'h1;
        end
      end
      ST_CMD: begin
        if (tick) begin
          if (cnt == 4'h1) begin
            next_cnt = ISABC_END_TICKS;
            next_state = ST_END;
          end else next_cnt = cnt - 4'h1;
        end
      end
      ST_END: begin
        if (tick) begin
          if (cnt == 4'h1) begin
            next_state = ST_IDLE;
            next_done = 1'b1;
          end else next_cnt = cnt - 4'h1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_ready = (next_state == ST_IDLE);
    next_master_n = (next_state == ST_IDLE);
    // drive address and strobes only while ownership is held, never before
    next_oe = (next_state != ST_IDLE) && (next_state != ST_ACQ);
    next_cmd = ISABC_CMD_IDLE;
    next_refresh_n = 1'b1;
    if (next_state == ST_CMD) begin
      case (next_cur.kind)
        ISABC_MEM_RD: next_cmd.memr_n = 1'b0;
        ISABC_MEM_WR: next_cmd.memw_n = 1'b0;
        ISABC_IO_RD: next_cmd.ior_n = 1'b0;
        ISABC_IO_WR: next_cmd.iow_n = 1'b0;
        ISABC_REFRESH: begin
          next_cmd.memr_n = 1'b0;
          next_refresh_n = 1'b0;
        end
        default: next_cmd = ISABC_CMD_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      cur <= '0;
      cmd_o <= ISABC_CMD_IDLE;
      cmd_oe_o <= 1'b0;
      la20_oe_o <= 1'b0;
      sa0_oe_o <= 1'b0;
      refresh_oe_o <= 1'b0;
      refresh_n_o <= 1'b1;
      master_n_o <= 1'b1;
      done_o <= 1'b0;
      req_ready_o <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur <= next_cur;
      cmd_o <= next_cmd;
      cmd_oe_o <= next_oe;
      la20_oe_o <= next_oe;
      sa0_oe_o <= next_oe;
      refresh_oe_o <= next_oe;
      refresh_n_o <= next_refresh_n;
      master_n_o <= next_master_n;
      done_o <= next_done;
      req_ready_o <= next_ready;
    end
  end
  assign la20_o = cur.addr[ISABC_ADDR_LA20];
  assign sa0_o = cur.addr[ISABC_ADDR_SA0];

  // card answers, glue and multiplexer: one registered group
  logic next_io16_n, next_mem16_n, next_zws_n, next_rdy, next_chk_n;
  logic next_smemr_n, next_smemw_n, next_drq, next_set1, next_set0, next_pmc, next_busrst;
  logic [7:0] next_ack_n;
  logic [2:0] ack_ch;
  logic ctl_io, ctl_mem;
  always_comb begin
    ctl_io = ~cmd_s.ior_n | ~cmd_s.iow_n;
    ctl_mem = ~cmd_s.memr_n | ~cmd_s.memw_n;
    next_io16_n = ~(card_io16_i & ctl_io);
    next_mem16_n = ~(card_mem16_i & ctl_mem);
    next_zws_n = ~(card_zero_wait_i & (ctl_io | ctl_mem));
    next_rdy = ~card_not_ready_i;
    next_chk_n = ~chan_error_i;
    next_smemr_n = cmd_s.memr_n | low_megabyte_qualifier_n_s;
    next_smemw_n = cmd_s.memw_n | low_megabyte_qualifier_n_s;
    next_drq = drq_src_i[isabc_map(ISABC_DRQ_MAP, sel_s)];
    next_set1 = set1_src_i[isabc_map(ISABC_SET1_MAP, sel_s)];
    next_set0 = set0_src_i[isabc_map(ISABC_SET0_MAP, sel_s)];
    next_pmc = pmc_src_i[isabc_map(ISABC_PMC_MAP, sel_s)];
    ack_ch = isabc_map(ISABC_ACK_MAP, sel_s);
    next_ack_n = 8'hff;
    next_busrst = 1'b0;
    if (acken_s) begin
      if (ack_ch == ISABC_ACK_BUS_RESET) next_busrst = 1'b1;
      else next_ack_n[ack_ch] = 1'b0;
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      io16_n_o <= 1'b1;
      mem16_n_o <= 1'b1;
      zero_wait_n_o <= 1'b1;
      iochrdy_o <= 1'b1;
      channel_check_input_n_o <= 1'b1;
      small_memr_n_o <= 1'b1;
      small_memw_n_o <= 1'b1;
      multiplexed_request_input_o <= 1'b0;
      interrupt_set_input_one_o <= 1'b0;
      interrupt_set_input_zero_o <= 1'b0;
      power_management_mux_input_o <= 1'b0;
      dma_ack_n_o <= 8'hff;
      bus_reset_o <= 1'b0;
    end else begin
      io16_n_o <= next_io16_n;
      mem16_n_o <= next_mem16_n;
      zero_wait_n_o <= next_zws_n;
      iochrdy_o <= next_rdy;
      channel_check_input_n_o <= next_chk_n;
      small_memr_n_o <= next_smemr_n;
      small_memw_n_o <= next_smemw_n;
      multiplexed_request_input_o <= next_drq;
      interrupt_set_input_one_o <= next_set1;
      interrupt_set_input_zero_o <= next_set0;
      power_management_mux_input_o <= next_pmc;
      dma_ack_n_o <= next_ack_n;
      bus_reset_o <= next_busrst;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    req_valid_i && state == ST_IDLE;
  endsequence
  sequence s_own;
    !master_n_o && !cmd_oe_o;
  endsequence
  a_drive_needs_own: assert property (cmd_oe_o |-> !master_n_o)
    else $error("strobes driven without ownership");
  a_take_then_own: assert property (s_take |=> s_own)
    else $error("ownership not taken after request");
  a_release_pins: assert property (master_n_o |-> !cmd_oe_o && !la20_oe_o && !sa0_oe_o)
    else $error("pins driven outside master operation");
  a_refresh_memr: assert property (!refresh_n_o |-> !cmd_o.memr_n && refresh_oe_o)
    else $error("refresh without memory read");
  a_addr_pins: assert property (s_take |=> la20_o == $past(req_i.addr[20]) &&
      sa0_o == $past(req_i.addr[0]))
    else $error("address pins wrong");
  a_smem_glue: assert property (small_memr_n_o == $past(cmd_s.memr_n | low_megabyte_qualifier_n_s))
    else $error("small memory read wrong");
  a_ready_hold: assert property (card_not_ready_i [*2] |-> !iochrdy_o)
    else $error("ready not held low");
  a_mem16_cause: assert property (card_mem16_i && !(cmd_s.memr_n && cmd_s.memw_n) |=> !mem16_n_o)
    else $error("16-bit memory not signalled");
  a_done_bound: assert property (s_take |-> ##[8:1000] done_o)
    else $error("master cycle never ended");
  a_ack_decode: assert property (bus_reset_o |-> dma_ack_n_o == 8'hff)
    else $error("acknowledge with bus reset");
endmodule
`default_nettype wire

// >>> isabc_ctrl_model.sv
/*
 Behavioural system controller opposite the expansion-bus partner.
 Assumes the bench resolves the two-way pins and commands strobes and select codes.
*/
`timescale 1ns/1ps
`default_nettype none
module isabc_ctrl_model #(
  parameter int DIV = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // bench commands
  input wire isabc_pkg::isabc_cmd_t strobe_i,
  input wire logic [23:0] addr_i,
  input wire logic refresh_i,
  input wire logic [2:0] code_i,
  input wire logic ack_en_i,
  // pins seen
  input wire logic master_n_i,
  input wire isabc_pkg::isabc_cmd_t cmd_i,
  input wire logic refresh_n_i,
  input wire logic chk_n_i,
  // pins driven
  output logic sysclk_o,
  output logic bale_o,
  output logic aen_o,
  output logic low_megabyte_qualifier_n_o,
  output logic ack_en_o,
  output logic [2:0] sel_o,
  output isabc_pkg::isabc_cmd_t cmd_o,
  output logic drive_o,
  output logic refresh_n_o,
  output logic nmi_o,
  output logic dram_refresh_o
);
  import isabc_pkg::*;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_sysclk;
  logic next_bale;
  // pins turn round as soon as the master claims the bus
  assign drive_o = master_n_i;
  assign cmd_o = strobe_i;
  assign low_megabyte_qualifier_n_o = (addr_i >= 24'h100000);
  assign aen_o = refresh_i;
  assign refresh_n_o = ~refresh_i;
  assign dram_refresh_o = ~master_n_i & ~refresh_n_i & ~cmd_i.memr_n;
  always_comb begin
    next_cnt = (cnt == 8'(DIV / 2 - 1)) ? 8'h0 : cnt + 8'h1;
    next_sysclk = (next_cnt == 8'h0) ? ~sysclk_o : sysclk_o;
    next_bale = (next_cnt == 8'h0) ? (~sysclk_o & drive_o) : bale_o;
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h0;
      sysclk_o <= 1'b0;
      bale_o <= 1'b0;
      nmi_o <= 1'b0;
      sel_o <= 3'h0;
      ack_en_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sysclk_o <= next_sysclk;
      bale_o <= next_bale;
      nmi_o <= ~chk_n_i;
      sel_o <= code_i;
      ack_en_o <= ack_en_i;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
/*
 Self-checking bench for the expansion-bus partner against a controller model.
 Assumes released strobes and refresh are pulled high on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isabc_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, req_valid = 1'b0, refresh = 1'b0, ack_en = 1'b0;
  logic c_io16 = 1'b0, c_mem16 = 1'b0, c_zw = 1'b0, c_nr = 1'b0, c_err = 1'b0;
  logic [7:0] drq = 8'ha5, set1 = 8'h3c, set0 = 8'h96, pmc = 8'h5a;
  logic [23:0] m_addr = 24'h0;
  logic [2:0] code = 3'h0;
  isabc_req_t req = '0;
  isabc_cmd_t strobe = ISABC_CMD_IDLE;
  isabc_cmd_t h_cmd, m_cmd, cmd_pin;
  logic ready, done, h_cmd_oe, la20, la20_oe, sa0, sa0_oe, h_ref_n, h_ref_oe, master_n;
  logic io16_n, mem16_n, zw_n, iochrdy, chk_n, smemr_n, smemw_n, multiplexed_request_input, s1, s0, pm, bus_rst;
  logic sysclk, bale, aen, low_megabyte_qualifier_n, ack_en_p, m_drive, m_ref_n, nmi, dram_ref, ref_pin;
  logic [2:0] sel;
  logic [7:0] dack_n;
  int err_total = 0;
  int cmp_count = 0;
  logic [23:0] addrs [5] = '{24'h0ffff1, 24'h100000, 24'h0ffffe, 24'h1fffff, 24'h000000};
  // released strobes float high through the bus pull-ups
  assign cmd_pin = h_cmd_oe ? h_cmd : (m_drive ? m_cmd : ISABC_CMD_IDLE);
  assign ref_pin = h_ref_oe ? h_ref_n : (m_drive ? m_ref_n : 1'b1);
  always #2.5 clock_i = ~clock_i;

  // 32 clock cycles give the 160 ns system clock
  isabc_ctrl_model #(.DIV(32)) isabc_ctrl_model_i (.clock_i(clock_i), .rst_i(rst_i),
    .strobe_i(strobe), .addr_i(m_addr), .refresh_i(refresh), .code_i(code), .ack_en_i(ack_en),
    .master_n_i(master_n), .cmd_i(cmd_pin), .refresh_n_i(ref_pin), .chk_n_i(chk_n),
    .sysclk_o(sysclk), .bale_o(bale), .aen_o(aen), .low_megabyte_qualifier_n_o(low_megabyte_qualifier_n), .ack_en_o(ack_en_p),
    .sel_o(sel), .cmd_o(m_cmd), .drive_o(m_drive), .refresh_n_o(m_ref_n), .nmi_o(nmi),
    .dram_refresh_o(dram_ref));

  isabc_host isabc_host_i (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(ready), .done_o(done), .card_io16_i(c_io16),
    .card_mem16_i(c_mem16), .card_zero_wait_i(c_zw), .card_not_ready_i(c_nr),
    .chan_error_i(c_err), .drq_src_i(drq), .set1_src_i(set1), .set0_src_i(set0),
    .pmc_src_i(pmc), .sysclk_i(sysclk), .bale_i(bale), .aen_i(aen),
    .low_megabyte_qualifier_n_i(low_megabyte_qualifier_n), .acknowledge_decode_enable_i(ack_en_p),
    .mux_select_bit2_i(sel[2]), .mux_select_bit1_i(sel[1]), .mux_select_bit0_i(sel[0]),
    .cmd_i(cmd_pin), .refresh_n_i(ref_pin), .cmd_o(h_cmd), .cmd_oe_o(h_cmd_oe),
    .la20_o(la20), .la20_oe_o(la20_oe), .sa0_o(sa0), .sa0_oe_o(sa0_oe),
    .refresh_n_o(h_ref_n), .refresh_oe_o(h_ref_oe), .master_n_o(master_n),
    .io16_n_o(io16_n), .mem16_n_o(mem16_n), .zero_wait_n_o(zw_n), .iochrdy_o(iochrdy),
    .channel_check_input_n_o(chk_n), .small_memr_n_o(smemr_n), .small_memw_n_o(smemw_n),
    .multiplexed_request_input_o(multiplexed_request_input), .interrupt_set_input_one_o(s1),
    .interrupt_set_input_zero_o(s0), .power_management_mux_input_o(pm),
    .dma_ack_n_o(dack_n), .bus_reset_o(bus_rst));

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one master cycle; strobe checks land well inside the three-tick command phase
  task automatic t_master(input isabc_kind_t k, input logic [23:0] a);
    int n;
    int low;
    logic seen;
    isabc_cmd_t exp;
    n = 0;
    low = 0;
    seen = 1'b0;
    exp = (k == ISABC_REFRESH) ? 4'b0111 : ~(4'b1000 >> k);
    @(posedge clock_i);
    req_valid <= 1'b1;
    req <= '{kind: k, addr: a};
    m_addr <= a;
    @(posedge clock_i);
    req_valid <= 1'b0;
    while (n < 400 && seen !== 1'b1) begin
      wait_n(1);
      n++;
      if (cmd_pin !== ISABC_CMD_IDLE) low++;
      if (low == 8) begin
        chk(cmd_pin === exp && m_drive === 1'b0, "master strobe");
        chk(la20_oe === 1'b1 && la20 === a[20], "la20 from master");
        chk(sa0_oe === 1'b1 && sa0 === a[0], "sa0 from master");
        chk(smemr_n === !(exp.memr_n == 1'b0 && a < 24'h100000), "small read");
        chk(smemw_n === !(exp.memw_n == 1'b0 && a < 24'h100000), "small write");
        chk(dram_ref === (k == ISABC_REFRESH), "master refresh");
      end
      seen = done;
    end
    chk(seen === 1'b1 && low > 8 && master_n === 1'b1 && h_cmd_oe === 1'b0, "cycle end");
  endtask

  // controller strobe with one card line asserted, then released
  task automatic t_card(input int i);
    @(posedge clock_i);
    strobe <= (i == 0) ? 4'b1101 : ((i == 1) ? 4'b0111 : 4'b1011);
    {c_io16, c_mem16, c_zw} <= 3'b100 >> i;
    wait_n(8);
    chk({io16_n, mem16_n, zw_n} === ~(3'b100 >> i), "card width or wait");
    @(posedge clock_i);
    strobe <= ISABC_CMD_IDLE;
    wait_n(8);
    chk({io16_n, mem16_n, zw_n} === 3'b111, "card lines idle");
    @(posedge clock_i);
    {c_io16, c_mem16, c_zw} <= 3'b000;
  endtask

  task automatic t_ready_error();
    @(posedge clock_i);
    c_nr <= 1'b1;
    c_err <= 1'b1;
    wait_n(8);
    chk(iochrdy === 1'b0, "not ready");
    chk(chk_n === 1'b0 && nmi === 1'b1, "channel check");
    @(posedge clock_i);
    c_nr <= 1'b0;
    c_err <= 1'b0;
    wait_n(8);
    chk(iochrdy === 1'b1 && chk_n === 1'b1 && nmi === 1'b0, "ready restored");
  endtask

  task automatic t_mux(input int c);
    @(posedge clock_i);
    code <= 3'(c);
    ack_en <= 1'b1;
    wait_n(8);
    chk({multiplexed_request_input, s1, s0, pm} === {drq[c], set1[c], set0[c], pmc[c]}, "mux source");
    chk(dack_n === ((c == 4) ? 8'hff : ~(8'h01 << c)) && bus_rst === (c == 4), "ack");
    @(posedge clock_i);
    ack_en <= 1'b0;
    wait_n(8);
    chk(dack_n === 8'hff && bus_rst === 1'b0, "ack disabled");
  endtask

  initial begin
    wait_n(8);
    chk(master_n === 1'b1 && h_cmd_oe === 1'b0 && ready === 1'b1, "reset state");
    @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) t_master(isabc_kind_t'(i), addrs[i]);
    for (int i = 0; i < 3; i++) t_card(i);
    t_ready_error();
    for (int c = 0; c < 8; c++) t_mux(c);
    final_report();
  end

  initial begin
    #100us;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
